// [dbsm_speed_monitor.sv]
`timescale 1ns/100ps
`include "dbsm_defines.svh"
// Behaviour
// (RL1) monitoring on at reset; only a keyed factory write may turn it off
// (RL2) four display units; percentage of calibrated speed is the reset default
// (RL3) revolutions and user units use a scale factor, reset value 20
// (RL4) scaled display is pulses per minute times factor over 12
// (RL5) three detection sources; dedicated speed input is the reset default
// (RL6) bucket sensor pulses give speed and alignment skew between sensors
// (RL7) differential: speed 1 dedicated input, speed 2 head and/or tail inputs
// (RL8) speed 2 is the highest rate among enabled head/tail inputs
// (RL9) differential works only with alignment enabled and inputs pulsed
// (RL10) calibration measures both speeds and stores speed2/speed1 ratio
// (RL11) ratio below 0.1 or above 10.0 fails calibration, not stored
// (RL12) live relation compared to stored ratio; deviation raises alarm
// (RL13) speeds moving together at the calibrated ratio raise no fault
// (RL14) slip is speed 2 against speed 1 times stored ratio
// (RL15) edited settings apply only after a yes save; else old ones kept
// (RL16) underspeed when measured below expected by configured percentage
// (RL17) overspeed when measured above expected by configured percentage
// (RL18) rate is rising edges counted per fixed window, in pulses per minute
module dbsm_speed_monitor #(
   parameter int WINDOW_CYCLES = `DBSM_WINDOW_CYC,
   parameter int RATE_W        = 24
) (
   input  wire logic        core_clk,
   input  wire logic        srst,
   input  wire logic        speed_in,
   input  wire logic [1:0]  head_align_in,
   input  wire logic [1:0]  tail_align_in,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   output logic             irq,
   output logic             underspeed_alarm,
   output logic             overspeed_alarm
);
   localparam int CNT_W = 24;

   function automatic logic [47:0] mul48(input logic [23:0] a, input logic [23:0] b);
      return {24'h0, a} * {24'h0, b};
   endfunction

   function automatic logic [47:0] div48(input logic [47:0] n, input logic [47:0] d);
      return (d == 48'h0) ? 48'h0 : n / d;
   endfunction

   function automatic logic [23:0] max2(input logic [23:0] a, input logic [23:0] b);
      return (a > b) ? a : b;
   endfunction

   // pin sync and edges
   logic [4:0] sync1_q, sync2_q, prev_q, edge_w;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         sync1_q <= 5'h00;
         sync2_q <= 5'h00;
         prev_q  <= 5'h00;
      end else begin
         sync1_q <= {tail_align_in, head_align_in, speed_in};
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end
   assign edge_w = sync2_q & ~prev_q; // RL18

   // time base and rates
   logic [31:0]       win_q;
   logic              tick_q;
   logic [CNT_W-1:0]  cnt_q  [5];
   logic [RATE_W-1:0] rate_q [5];
   wire               win_end = (win_q == 32'(WINDOW_CYCLES - 1));
   always_ff @(posedge core_clk) begin
      if (srst) begin
         win_q  <= 32'h0;
         tick_q <= 1'b0;
      end else begin
         win_q  <= win_end ? 32'h0 : win_q + 32'h1;
         tick_q <= win_end;
      end
   end
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < 5; i++) begin
         if (srst) begin
            cnt_q[i]  <= '0;
            rate_q[i] <= '0;
         end else if (win_end) begin
            cnt_q[i]  <= CNT_W'(edge_w[i]);
            rate_q[i] <= RATE_W'(mul48(cnt_q[i], 24'(`DBSM_PPM_PER_CNT))); // RL18
         end else begin
            cnt_q[i] <= cnt_q[i] + CNT_W'(edge_w[i]);
         end
      end
   end

   // configuration: active and staged copies
   dbsm_pkg::dbsm_unit_t   unit_q, unit_stg_q;
   dbsm_pkg::dbsm_source_t src_q, src_stg_q;
   logic                   head_en_q, tail_en_q, pulsed_q;
   logic                   head_en_stg_q, tail_en_stg_q, pulsed_stg_q;
   logic [15:0]            scale_q, scale_stg_q;
   logic [3:0]             under_pct_q, over_pct_q, under_stg_q, over_stg_q;
   logic                   monitor_en_q;
   logic [3:0]             mask_q;
   wire wr_cfg   = reg_wr && reg_addr == `DBSM_CFG_OFS;
   wire wr_scale = reg_wr && reg_addr == `DBSM_SCALE_OFS;
   wire wr_limit = reg_wr && reg_addr == `DBSM_LIMIT_OFS;
   wire wr_save  = reg_wr && reg_addr == `DBSM_SAVE_OFS;
   wire save_yes = wr_save && reg_wdata == `DBSM_SAVE_YES;
   wire wr_fact  = reg_wr && reg_addr == `DBSM_FACTORY_OFS && reg_wdata[31:8] == `DBSM_FACTORY_KEY;
   wire wr_cal   = reg_wr && reg_addr == `DBSM_CAL_OFS && reg_wdata[0];

   // staged edits; a save without yes throws them away
   always_ff @(posedge core_clk) begin
      if (srst) begin
         unit_stg_q    <= dbsm_pkg::percent_of_calibrated_unit;
         src_stg_q     <= dbsm_pkg::dedicated_speed_source;
         head_en_stg_q <= 1'b0;
         tail_en_stg_q <= 1'b0;
         pulsed_stg_q  <= 1'b0;
         scale_stg_q   <= `DBSM_SCALE_RST;
         under_stg_q   <= `DBSM_UNDER_RST;
         over_stg_q    <= `DBSM_OVER_RST;
      end else if (wr_save && !save_yes) begin // RL15
         unit_stg_q    <= unit_q;
         src_stg_q     <= src_q;
         head_en_stg_q <= head_en_q;
         tail_en_stg_q <= tail_en_q;
         pulsed_stg_q  <= pulsed_q;
         scale_stg_q   <= scale_q;
         under_stg_q   <= under_pct_q;
         over_stg_q    <= over_pct_q;
      end else begin
         if (wr_cfg) begin
            unit_stg_q    <= dbsm_pkg::dbsm_unit_t'(reg_wdata[`DBSM_CFG_UNIT_LSB +: 2]);
            src_stg_q     <= dbsm_pkg::dbsm_source_t'(reg_wdata[`DBSM_CFG_SRC_LSB +: 2]);
            head_en_stg_q <= reg_wdata[`DBSM_CFG_HEAD_BIT];
            tail_en_stg_q <= reg_wdata[`DBSM_CFG_TAIL_BIT];
            pulsed_stg_q  <= reg_wdata[`DBSM_CFG_PULS_BIT];
         end
         if (wr_scale)
            scale_stg_q <= reg_wdata[15:0];
         if (wr_limit) begin
            under_stg_q <= reg_wdata[3:0];
            over_stg_q  <= reg_wdata[`DBSM_LIM_OVER_LSB +: 4];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         unit_q      <= dbsm_pkg::percent_of_calibrated_unit; // RL2
         src_q       <= dbsm_pkg::dedicated_speed_source; // RL5
         head_en_q   <= 1'b0;
         tail_en_q   <= 1'b0;
         pulsed_q    <= 1'b0;
         scale_q     <= `DBSM_SCALE_RST; // RL3
         under_pct_q <= `DBSM_UNDER_RST; // RL16
         over_pct_q  <= `DBSM_OVER_RST; // RL17
      end else if (save_yes) begin // RL15
         unit_q      <= unit_stg_q;
         src_q       <= src_stg_q;
         head_en_q   <= head_en_stg_q;
         tail_en_q   <= tail_en_stg_q;
         pulsed_q    <= pulsed_stg_q;
         scale_q     <= scale_stg_q;
         under_pct_q <= under_stg_q;
         over_pct_q  <= over_stg_q;
      end
   end

   // ordinary profile writes cannot reach this bit
   always_ff @(posedge core_clk) begin
      if (srst)
         monitor_en_q <= 1'b1; // RL1
      else if (wr_fact)
         monitor_en_q <= reg_wdata[0]; // RL1
   end

   always_ff @(posedge core_clk) begin
      if (srst)
         mask_q <= 4'h0;
      else if (reg_wr && reg_addr == `DBSM_MASK_OFS)
         mask_q <= reg_wdata[3:0];
   end

   // speed selection
   logic [23:0] align_max, align_min, speed1, speed2;
   logic        diff_mode, diff_ok;
   always_comb begin
      align_max = 24'h0;
      align_min = 24'hFF_FFFF;
      if (head_en_q) begin
         align_max = max2(align_max, max2(24'(rate_q[1]), 24'(rate_q[2]))); // RL8
         align_min = ~max2(~align_min, max2(~24'(rate_q[1]), ~24'(rate_q[2])));
      end
      if (tail_en_q) begin
         align_max = max2(align_max, max2(24'(rate_q[3]), 24'(rate_q[4]))); // RL8
         align_min = ~max2(~align_min, max2(~24'(rate_q[3]), ~24'(rate_q[4])));
      end
      diff_mode = src_q == dbsm_pkg::differential_speed_source;
      diff_ok   = pulsed_q && (head_en_q || tail_en_q); // RL9
      speed1    = (src_q == dbsm_pkg::bucket_motion_sensor_source) ? align_max : 24'(rate_q[0]); // RL6 RL7
      speed2    = align_max; // RL7
   end

   // bucket mode: spread between fastest and slowest sensor marks misalignment
   logic [23:0] skew_q;
   always_ff @(posedge core_clk) begin
      if (srst)
         skew_q <= 24'h0;
      else if (tick_q)
         skew_q <= (align_max >= align_min) ? align_max - align_min : 24'h0; // RL6
   end

   // calibration
   dbsm_pkg::dbsm_cal_state_t cal_st_q;
   logic [15:0] ratio_q;
   logic [23:0] cal_speed_q;
   logic        calibrated_q, cal_ok_ev, cal_fail_ev;
   wire  [47:0] s1x = {24'h0, speed1};
   wire  [47:0] s2x = {24'h0, speed2};
   wire         ratio_bad = diff_mode && (mul48(speed2, 24'hA) < s1x
                            || s2x > mul48(speed1, 24'hA) || !diff_ok); // RL11
   wire         cal_eval  = cal_st_q == dbsm_pkg::CAL_MEASURE && tick_q;
   wire         cal_fail  = ratio_bad || speed1 == 24'h0;
   assign cal_ok_ev   = cal_eval && !cal_fail;
   assign cal_fail_ev = cal_eval && cal_fail;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         cal_st_q <= dbsm_pkg::CAL_IDLE;
      end else begin
         unique case (cal_st_q)
            dbsm_pkg::CAL_IDLE:    if (wr_cal) cal_st_q <= dbsm_pkg::CAL_ARM;
            dbsm_pkg::CAL_ARM:     if (tick_q) cal_st_q <= dbsm_pkg::CAL_MEASURE; // partial window discarded
            dbsm_pkg::CAL_MEASURE: if (tick_q) cal_st_q <= dbsm_pkg::CAL_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         ratio_q      <= 16'h0;
         cal_speed_q  <= 24'h0;
         calibrated_q <= 1'b0;
      end else if (wr_cal) begin
         calibrated_q <= 1'b0;
      end else if (cal_ok_ev) begin
         ratio_q      <= 16'(div48(s2x << `DBSM_RATIO_FRAC, s1x)); // RL10
         cal_speed_q  <= speed1;
         calibrated_q <= 1'b1;
      end
   end

   // slip / speed comparison
   logic [47:0] meas, expect_spd;
   always_comb begin
      if (diff_mode) begin
         meas       = s2x;
         expect_spd = mul48(speed1, 24'(ratio_q)) >> `DBSM_RATIO_FRAC; // RL14
      end else begin
         meas       = s1x;
         expect_spd = {24'h0, cal_speed_q};
      end
   end
   wire [47:0] meas_pct  = mul48(meas[23:0], 24'h64);
   wire [47:0] lo_bound  = mul48(expect_spd[23:0], 24'(8'h64 - {4'h0, under_pct_q}));
   wire [47:0] hi_bound  = mul48(expect_spd[23:0], 24'(8'h64 + {4'h0, over_pct_q}));
   wire        armed     = monitor_en_q && calibrated_q && (!diff_mode || diff_ok); // RL1 RL9
   logic       under_q, over_q, under_ev, over_ev;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         under_q <= 1'b0;
         over_q  <= 1'b0;
      end else if (!armed) begin
         under_q <= 1'b0;
         over_q  <= 1'b0;
      end else if (tick_q) begin
         under_q <= meas_pct < lo_bound; // RL12 RL13 RL16
         over_q  <= meas_pct > hi_bound; // RL12 RL13 RL17
      end
   end
   logic under_prev_q, over_prev_q;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         under_prev_q <= 1'b0;
         over_prev_q  <= 1'b0;
      end else begin
         under_prev_q <= under_q;
         over_prev_q  <= over_q;
      end
   end
   assign under_ev         = under_q && !under_prev_q;
   assign over_ev          = over_q && !over_prev_q;
   assign underspeed_alarm = under_q;
   assign overspeed_alarm  = over_q;

   // display
   logic [31:0] display_q;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         display_q <= 32'h0;
      end else begin
         unique case (unit_q)
            dbsm_pkg::pulses_per_minute_unit:
               display_q <= 32'(meas);
            dbsm_pkg::revolutions_per_minute_unit, dbsm_pkg::user_defined_unit:
               display_q <= 32'(div48(mul48(meas[23:0], {8'h0, scale_q}), `DBSM_SCALE_DIV)); // RL4
            dbsm_pkg::percent_of_calibrated_unit:
               display_q <= 32'(div48(meas_pct, expect_spd)); // RL2
         endcase
      end
   end

   // status, interrupt, read port
   logic [3:0] status_q;
   wire        rd_status = reg_rd && reg_addr == `DBSM_STATUS_OFS;
   wire  [3:0] events    = {over_ev, under_ev, cal_fail_ev, cal_ok_ev};
   // a new event in the clearing cycle survives
   always_ff @(posedge core_clk) begin
      if (srst)
         status_q <= 4'h0;
      else
         status_q <= (rd_status ? 4'h0 : status_q) | events;
   end
   assign irq = |(status_q & mask_q);

   always_ff @(posedge core_clk) begin
      if (srst) begin
         reg_rdata <= 32'h0;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `DBSM_CFG_OFS:     reg_rdata <= {25'h0, pulsed_stg_q, tail_en_stg_q, head_en_stg_q,
                                             src_stg_q, unit_stg_q};
            `DBSM_SCALE_OFS:   reg_rdata <= {16'h0, scale_stg_q};
            `DBSM_LIMIT_OFS:   reg_rdata <= {20'h0, over_stg_q, 4'h0, under_stg_q};
            `DBSM_FACTORY_OFS: reg_rdata <= {31'h0, monitor_en_q};
            `DBSM_CAL_OFS:     reg_rdata <= {30'h0, calibrated_q, cal_st_q != dbsm_pkg::CAL_IDLE};
            `DBSM_STATUS_OFS:  reg_rdata <= {28'h0, status_q};
            `DBSM_MASK_OFS:    reg_rdata <= {28'h0, mask_q};
            `DBSM_SPEED1_OFS:  reg_rdata <= {8'h0, speed1};
            `DBSM_SPEED2_OFS:  reg_rdata <= {8'h0, speed2};
            `DBSM_DISPLAY_OFS: reg_rdata <= display_q;
            `DBSM_RATIO_OFS:   reg_rdata <= {16'h0, ratio_q};
            `DBSM_SKEW_OFS:    reg_rdata <= {8'h0, skew_q};
            default:           reg_rdata <= 32'h0;
         endcase
      end else begin
         reg_rdata <= 32'h0;
      end
   end

   // assertions
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (srst);

   sequence s_cal_start; wr_cal && cal_st_q == dbsm_pkg::CAL_IDLE; endsequence
   sequence s_cal_armed; cal_st_q == dbsm_pkg::CAL_ARM && !calibrated_q; endsequence

   a_reset_defaults: assert property ($past(srst) |-> monitor_en_q && scale_q == 16'h0014 // RL1
      && unit_q == dbsm_pkg::percent_of_calibrated_unit && src_q == dbsm_pkg::dedicated_speed_source)
      else $error("defaults wrong after reset");
   a_monitor_lock: assert property ($fell(monitor_en_q) |-> $past(wr_fact)) // RL1
      else $error("monitor disabled without factory write");
   a_save_gate: assert property ($changed(scale_q) || $changed(unit_q) |-> $past(save_yes)) // RL15
      else $error("settings changed without yes save");
   a_scaled_disp: assert property (unit_q == dbsm_pkg::revolutions_per_minute_unit && $stable(meas) // RL4
      && $stable(scale_q) |=> display_q == 32'((mul48($past(meas[23:0]), {8'h0, scale_q})) / 48'hC))
      else $error("scaled display wrong");
   a_speed2_max: assert property (diff_mode && head_en_q |-> speed2 >= 24'(rate_q[1]) // RL8
      && speed2 >= 24'(rate_q[2])) else $error("speed 2 not highest input");
   a_ratio_range: assert property (cal_ok_ev && diff_mode |=> ratio_q >= 16'h0019 // RL11
      && ratio_q <= 16'h0A00 && calibrated_q) else $error("accepted ratio out of range");
   a_cal_fail_keep: assert property (cal_fail_ev |=> !calibrated_q) // RL11
      else $error("failed calibration accepted");
   a_cal_sequence: assert property (s_cal_start |=> s_cal_armed) // RL10
      else $error("calibration did not arm");
   a_diff_gate: assert property (diff_mode && !diff_ok |=> !under_q && !over_q) // RL9
      else $error("alarm in unusable differential setup");
   a_under_cause: assert property ($rose(under_q) |-> $past(tick_q) && $past(meas_pct < lo_bound)) // RL16
      else $error("underspeed without cause");
   a_over_cause: assert property ($rose(over_q) |-> $past(tick_q) && $past(meas_pct > hi_bound)) // RL17
      else $error("overspeed without cause");
   a_status_sticky: assert property (under_ev |=> status_q[`DBSM_ST_UNDER]) // RL16
      else $error("underspeed event lost");
endmodule

// [dbsm_defines.svh]
`ifndef DBSM_DEFINES_SVH
`define DBSM_DEFINES_SVH

// register byte offsets
`define DBSM_CFG_OFS      8'h00
`define DBSM_SCALE_OFS    8'h04
`define DBSM_LIMIT_OFS    8'h08
`define DBSM_SAVE_OFS     8'h0C
`define DBSM_FACTORY_OFS  8'h10
`define DBSM_CAL_OFS      8'h14
`define DBSM_STATUS_OFS   8'h18
`define DBSM_MASK_OFS     8'h1C
`define DBSM_SPEED1_OFS   8'h20
`define DBSM_SPEED2_OFS   8'h24
`define DBSM_DISPLAY_OFS  8'h28
`define DBSM_RATIO_OFS    8'h2C
`define DBSM_SKEW_OFS     8'h30

// cfg and limit fields
`define DBSM_CFG_UNIT_LSB 0
`define DBSM_CFG_SRC_LSB  2
`define DBSM_CFG_HEAD_BIT 4
`define DBSM_CFG_TAIL_BIT 5
`define DBSM_CFG_PULS_BIT 6
`define DBSM_LIM_OVER_LSB 8

// status bits
`define DBSM_ST_CAL_OK    0
`define DBSM_ST_CAL_FAIL  1
`define DBSM_ST_UNDER     2
`define DBSM_ST_OVER      3

// reset values and write codes
`define DBSM_SCALE_RST    16'h0014
`define DBSM_UNDER_RST    4'hA
`define DBSM_OVER_RST     4'hA
`define DBSM_SAVE_YES     32'h0000_0001
`define DBSM_FACTORY_KEY  24'hA5C3E1

// arithmetic constants
`define DBSM_SCALE_DIV    48'h0000_0000_000C
`define DBSM_PCT_FULL     48'h0000_0000_0064
`define DBSM_RATIO_FRAC   8
`define DBSM_RATIO_MIN_X  48'h0000_0000_000A

// timing
`define DBSM_CLK_HZ       40000000
`define DBSM_WINDOW_MS    1000
`define DBSM_WINDOW_CYC   (`DBSM_WINDOW_MS * (`DBSM_CLK_HZ / 1000))
`define DBSM_PPM_PER_CNT  (60000 / `DBSM_WINDOW_MS)

`endif

// [dbsm_pkg.sv]
package dbsm_pkg;
   typedef enum logic [1:0] {
      pulses_per_minute_unit,
      revolutions_per_minute_unit,
      user_defined_unit,
      percent_of_calibrated_unit
   } dbsm_unit_t;

   typedef enum logic [1:0] {
      bucket_motion_sensor_source,
      dedicated_speed_source,
      differential_speed_source,
      reserved_source
   } dbsm_source_t;

   typedef enum {
      CAL_IDLE,
      CAL_ARM,
      CAL_MEASURE
   } dbsm_cal_state_t;
endpackage

// [dbsm_sensor_model.sv]
`timescale 1ns/100ps
// pulse sensors on the machine: channel 0 drives the dedicated speed pin,
// 1..2 the head alignment pins, 3..4 the tail alignment pins
module dbsm_sensor_model (
   input  wire logic       core_clk,
   input  int              period [5],
   output logic            speed_in,
   output logic [1:0]      head_align_in,
   output logic [1:0]      tail_align_in
);
   int         cnt [5];
   logic [4:0] pin_q = 5'h00;

   // one rising edge every period cycles; period 0 holds the pin low
   always_ff @(posedge core_clk) begin
      for (int i = 0; i < 5; i++) begin
         if (period[i] == 0 || cnt[i] >= period[i] - 1) begin
            cnt[i] <= 0;
         end else begin
            cnt[i] <= cnt[i] + 1;
         end
         pin_q[i] <= (period[i] != 0) && (cnt[i] < period[i] / 2);
      end
   end

   assign speed_in      = pin_q[0];
   assign head_align_in = pin_q[2:1];
   assign tail_align_in = pin_q[4:3];
endmodule

// [dbsm_speed_monitor_tb.sv]
`timescale 1ns/100ps
`include "dbsm_defines.svh"
module dbsm_speed_monitor_tb;
   // checked periods divide the window, so every window counts an exact number of edges
   localparam int WIN = 600;
   logic        core_clk  = 1'b0;
   logic        srst      = 1'b1;
   logic [7:0]  reg_addr  = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic        reg_wr    = 1'b0;
   logic        reg_rd    = 1'b0;
   logic [31:0] reg_rdata;
   logic        irq;
   logic        underspeed_alarm;
   logic        overspeed_alarm;
   logic        speed_in;
   logic [1:0]  head_align_in;
   logic [1:0]  tail_align_in;
   int          period [5] = '{default: 0};
   int          n_fail     = 0;
   int          n_tests    = 0;
   int          tab [4][3] = '{'{40, 20, 1}, '{200, 10, 0}, '{10, 200, 0}, '{40, 20, 1}};

   initial begin
      forever #12.5 core_clk = ~core_clk;
   end

   dbsm_speed_monitor #(.WINDOW_CYCLES(WIN)) u_dut (
      .core_clk         (core_clk),
      .srst             (srst),
      .speed_in         (speed_in),
      .head_align_in    (head_align_in),
      .tail_align_in    (tail_align_in),
      .reg_addr         (reg_addr),
      .reg_wdata        (reg_wdata),
      .reg_wr           (reg_wr),
      .reg_rd           (reg_rd),
      .reg_rdata        (reg_rdata),
      .irq              (irq),
      .underspeed_alarm (underspeed_alarm),
      .overspeed_alarm  (overspeed_alarm)
   );

   dbsm_sensor_model u_sensors (
      .core_clk      (core_clk),
      .period        (period),
      .speed_in      (speed_in),
      .head_align_in (head_align_in),
      .tail_align_in (tail_align_in)
   );

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   // a gap cycle after each strobe keeps every signal to one assignment per step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge core_clk);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] got;
      rd(a, got);
      chk(got, exp, what);
   endtask

   task automatic pins(input logic [2:0] exp, input string what);
      #1 chk({29'h0, irq, underspeed_alarm, overspeed_alarm}, {29'h0, exp}, what);
   endtask

   task automatic wait_win(input int n);
      repeat (n * WIN) @(posedge core_clk);
   endtask

   task automatic apply(input logic [31:0] c);
      wr(`DBSM_CFG_OFS, c);
      wr(`DBSM_SAVE_OFS, `DBSM_SAVE_YES);
   endtask

   function automatic logic [31:0] cfgw(input logic [1:0] u, input logic [1:0] s, input logic p);
      cfgw = 32'(u) | (32'(s) << `DBSM_CFG_SRC_LSB) | ({29'h0, p, p, p} << `DBSM_CFG_HEAD_BIT);
   endfunction

   // returns the control word once busy drops; a hang ends the run
   task automatic calibrate(output logic [31:0] c);
      int i;
      wr(`DBSM_CAL_OFS, 32'h0000_0001);
      for (i = 0; i < 3 * WIN; i++) begin
         rd(`DBSM_CAL_OFS, c);
         if (c[0] === 1'b0) break;
      end
      if (i == 3 * WIN) begin
         n_fail++;
         $display("unexpected at %0t: calibration never finished", $time);
         report_and_stop();
      end
   endtask

   initial begin
      logic [31:0] v;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      rd_chk(`DBSM_CFG_OFS, cfgw(2'h3, 2'h1, 1'b0), "cfg reset");
      rd_chk(`DBSM_SCALE_OFS, 32'h0000_0014, "scale reset");
      rd_chk(`DBSM_LIMIT_OFS, 32'h0000_0A0A, "limit reset");
      rd_chk(`DBSM_FACTORY_OFS, 32'h0000_0001, "monitor reset");
      rd_chk(8'h3C, 32'h0000_0000, "unmapped read");
      wr(`DBSM_FACTORY_OFS, 32'h0000_0000);
      rd_chk(`DBSM_FACTORY_OFS, 32'h0000_0001, "unkeyed factory write");
      wr(`DBSM_SCALE_OFS, 32'h0000_0018);
      wr(`DBSM_SAVE_OFS, 32'h0000_0000);
      rd_chk(`DBSM_SCALE_OFS, 32'h0000_0014, "unsaved scale");
      wr(`DBSM_SCALE_OFS, 32'h0000_0018);
      apply(cfgw(2'h0, 2'h1, 1'b0));
      rd_chk(`DBSM_SCALE_OFS, 32'h0000_0018, "saved scale");
      period[0] <= 20;
      wait_win(3);
      rd_chk(`DBSM_SPEED1_OFS, 32'(WIN / 20 * 60), "speed1 rate");
      calibrate(v);
      chk(v, 32'h0000_0002, "dedicated calibration");
      for (int u = 0; u < 4; u++) begin
         apply(cfgw(2'(u), 2'h1, 1'b0));
         wait_win(2);
         v = (u == 0) ? 1800 : (u == 3) ? 100 : 1800 * 24 / 12;
         rd_chk(`DBSM_DISPLAY_OFS, v, "display per unit");
      end
      // unit change without a yes save must leave the percent display alone
      wr(`DBSM_CFG_OFS, cfgw(2'h0, 2'h1, 1'b0));
      wr(`DBSM_SAVE_OFS, 32'h0000_0002);
      rd_chk(`DBSM_CFG_OFS, cfgw(2'h3, 2'h1, 1'b0), "reloaded cfg");
      wait_win(1);
      rd_chk(`DBSM_DISPLAY_OFS, 32'h0000_0064, "display kept");
      apply(cfgw(2'h0, 2'h0, 1'b1));
      period <= '{0, 10, 20, 30, 60};
      wait_win(3);
      rd_chk(`DBSM_SKEW_OFS, 32'(WIN / 10 * 60 - WIN / 60 * 60), "bucket skew");
      apply(cfgw(2'h3, 2'h2, 1'b0));
      period <= '{40, 20, 40, 0, 0};
      wait_win(3);
      calibrate(v);
      chk(v, 32'h0000_0000, "differential not pulsed");
      apply(cfgw(2'h3, 2'h2, 1'b1));
      // earlier calibrations and bucket-mode alarms left sticky bits behind
      rd(`DBSM_STATUS_OFS, v);
      for (int i = 0; i < 4; i++) begin
         period <= '{tab[i][0], tab[i][1], tab[i][1] * 2, 0, 0};
         wait_win(3);
         rd_chk(`DBSM_SPEED1_OFS, 32'(WIN / tab[i][0] * 60), "speed1 dedicated");
         rd_chk(`DBSM_SPEED2_OFS, 32'(WIN / tab[i][1] * 60), "speed2 highest");
         calibrate(v);
         chk(v, tab[i][2] ? 32'h0000_0002 : 32'h0000_0000, "calibrated flag");
         rd(`DBSM_STATUS_OFS, v);
         chk(v & 32'h3, tab[i][2] ? 32'h0000_0001 : 32'h0000_0002, "calibration status");
         rd_chk(`DBSM_RATIO_OFS, 32'h0000_0200, "stored ratio");
      end
      period <= '{20, 10, 20, 0, 0};
      wait_win(3);
      rd(`DBSM_STATUS_OFS, v);
      wait_win(2);
      pins(3'b000, "both speeds doubled");
      rd_chk(`DBSM_STATUS_OFS, 32'h0000_0000, "no events at ratio");
      rd_chk(`DBSM_DISPLAY_OFS, 32'h0000_0064, "percent at ratio");
      period[1] <= 12;
      wait_win(3);
      pins(3'b010, "underspeed masked");
      rd_chk(`DBSM_DISPLAY_OFS, 32'(3000 * 100 / (1800 * 512 / 256)), "slip percent");
      wr(`DBSM_MASK_OFS, 32'h0000_000F);
      pins(3'b110, "underspeed unmasked");
      rd(`DBSM_STATUS_OFS, v);
      chk(v & 32'hC, 32'h0000_0004, "underspeed event");
      pins(3'b010, "status cleared");
      period[1] <= 6;
      wait_win(3);
      pins(3'b101, "overspeed");
      rd(`DBSM_STATUS_OFS, v);
      chk(v & 32'hC, 32'h0000_0008, "overspeed event");
      wr(`DBSM_FACTORY_OFS, {`DBSM_FACTORY_KEY, 8'h00});
      wait_win(2);
      pins(3'b000, "monitor off");
      rd_chk(`DBSM_FACTORY_OFS, 32'h0000_0000, "keyed factory write");
      report_and_stop();
   end
endmodule
